// >>> design/scs_sequencer.sv
// What this block does
// - start rise ends acquisition, begins conversion
// - sixteen step search, msb first
// - done presents code and busy indication
// - conversion timed by own clock only
// - straight binary result coding
// - over range clips to all ones
// - under range clips to all zeros
// - compression setting held and driven out on span_enable_o, codes not remapped here
// - clamp engagement sets overvoltage flag
// - flag readable in config and status
// - flag active low
// - sticky, cleared by read when clear
// - compression off after reset
`timescale 1ns/1ns

module scs_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] PTR_STEP = {{AW{1'b0}}, 1'b1};
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } scs_fifo_s;
  scs_fifo_s cur;
  scs_fifo_s next_cur;
  logic full;
  logic empty;
  // one spare pointer bit tells full from empty, so every slot is usable
  assign full = (cur.wr_ptr[AW] != cur.rd_ptr[AW]) &&
                (cur.wr_ptr[AW-1:0] == cur.rd_ptr[AW-1:0]);
  assign empty = cur.wr_ptr == cur.rd_ptr;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  // head slot read straight out, so a pushed word shows one edge later
  assign out_data_o = cur.mem[cur.rd_ptr[AW-1:0]];
  always_comb begin
    next_cur = cur;
    if (in_valid_i && !full) begin
      next_cur.mem[cur.wr_ptr[AW-1:0]] = in_data_i;
      next_cur.wr_ptr = cur.wr_ptr + PTR_STEP;
    end
    if (out_ready_i && !empty) begin
      next_cur.rd_ptr = cur.rd_ptr + PTR_STEP;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule : scs_fifo

module scs_sequencer (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // conversion control from host
  input wire logic conversion_start_i,
  // analog front end
  input wire logic comparator_high_i,
  input wire logic over_range_i,
  input wire logic under_range_i,
  input wire logic clamp_active_i,
  output logic positive_array_ground_switch_o,
  output logic negative_array_ground_switch_o,
  output logic [scs_pkg::RES_W-1:0] dac_trial_o,
  // configuration access
  input wire logic span_write_i,
  input wire logic span_value_i,
  input wire logic config_read_i,
  output logic span_enable_o,
  output logic overvoltage_flag_n_o,
  // result stream
  output logic busy_o,
  output logic result_valid_o,
  input wire logic result_ready_i,
  output logic [scs_pkg::RES_W-1:0] result_code_o,
  output logic result_ov_n_o,
  output logic overflow_o
);
  import scs_pkg::*;

  typedef enum logic [1:0] {ST_ACQ, ST_OPEN, ST_SEARCH, ST_DONE} scs_state_e;

  typedef struct packed {
    scs_state_e st;
    logic [2:0] cnv_sync;
    logic [1:0] clamp_sync;
    logic [2:0] over_sync;
    logic [2:0] under_sync;
    logic [4:0] step;
    logic [15:0] trial;
    logic [15:0] code;
    logic span;
    logic ovf_n;
    logic lost;
  } scs_state_s;

  scs_state_s cur;
  scs_state_s next_cur;
  logic fifo_in_ready;
  logic fifo_push;
  logic [FIFO_W-1:0] fifo_out;
  logic cnv_rise;
  logic cmp_q;
  logic [15:0] bit_mask;

  function automatic logic [15:0] step_mask(input logic [4:0] s);
    step_mask = 16'h8000 >> s[3:0];
  endfunction : step_mask

  assign cnv_rise = cur.cnv_sync[1] && !cur.cnv_sync[2];
  // latched comparator strobed by this clock: read directly, since a
  // synchroniser would hand back the answer for a trial two steps old
  assign cmp_q = comparator_high_i;
  assign bit_mask = step_mask(cur.step);
  assign fifo_push = cur.st == ST_DONE;

  always_comb begin
    next_cur = cur;
    next_cur.cnv_sync = {cur.cnv_sync[1:0], conversion_start_i};
    next_cur.clamp_sync = {cur.clamp_sync[0], clamp_active_i};
    next_cur.over_sync = {cur.over_sync[1:0], over_range_i};
    next_cur.under_sync = {cur.under_sync[1:0], under_range_i};
    // range detect is relative to the active window chosen by span
    if (span_write_i) begin
      next_cur.span = span_value_i;
    end
    // read clears only when the clamp is off; set wins otherwise
    if (config_read_i && !cur.clamp_sync[1]) begin
      next_cur.ovf_n = 1'b1;
    end
    if (cur.clamp_sync[1]) begin
      next_cur.ovf_n = 1'b0;
    end
    unique case (cur.st)
      ST_ACQ: begin
        if (cnv_rise) begin
          next_cur.st = ST_OPEN;
          next_cur.trial = CODE_MID;
          next_cur.step = STEP_RESET;
        end
      end
      ST_OPEN: begin
        next_cur.st = ST_SEARCH;
      end
      ST_SEARCH: begin
        // comparator high means trial above input: drop the bit
        if (cmp_q) begin
          next_cur.trial = cur.trial & ~bit_mask;
        end
        if (cur.step < STEP_LAST) begin
          next_cur.trial = next_cur.trial | step_mask(cur.step + 5'h01);
          next_cur.step = cur.step + 5'h01;
        end else begin
          next_cur.st = ST_DONE;
          // clip, mapping is in the analog range flags for span mode
          if (cur.over_sync[2]) begin
            next_cur.code = CODE_FULL;
          end else if (cur.under_sync[2]) begin
            next_cur.code = CODE_ZERO;
          end else begin
            next_cur.code = next_cur.trial;
          end
        end
      end
      ST_DONE: begin
        next_cur.st = ST_ACQ;
        // a full buffer drops this code; overflow holds until reset
        next_cur.lost = cur.lost | !fifo_in_ready;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur <= '{st: ST_ACQ, cnv_sync: 3'h0, clamp_sync: 2'h0,
               over_sync: 3'h0, under_sync: 3'h0,
               step: STEP_RESET, trial: CODE_MID, code: CODE_ZERO,
               span: SPAN_RESET, ovf_n: OVF_N_RESET, lost: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  scs_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({cur.ovf_n, cur.code}),
    .out_valid_o(result_valid_o),
    .out_ready_i(result_ready_i),
    .out_data_o(fifo_out)
  );

  assign result_code_o = fifo_out[15:0];
  assign result_ov_n_o = fifo_out[16];
  assign overvoltage_flag_n_o = cur.ovf_n;
  assign span_enable_o = cur.span;
  // busy falls on the same edge that writes the code into the buffer
  assign busy_o = cur.st != ST_ACQ;
  assign dac_trial_o = cur.trial;
  // both switches open on the first conversion cycle, before any trial
  assign positive_array_ground_switch_o = cur.st == ST_ACQ;
  assign negative_array_ground_switch_o = cur.st == ST_ACQ;
  assign overflow_o = cur.lost;

  chk_busy_on_start: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cnv_rise && cur.st == ST_ACQ |=> busy_o)
    else $error("busy not raised after start");
  chk_search_length: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) $rose(busy_o) |-> ##17 cur.st == ST_DONE)
    else $error("search not sixteen steps");
  chk_busy_drop: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.st == ST_DONE |=> !busy_o)
    else $error("busy did not drop after done");
  chk_code_push: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.st == ST_DONE && fifo_in_ready
      |=> result_valid_o)
    else $error("finished code not offered");
  chk_over_clip: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.st == ST_SEARCH && cur.step == STEP_LAST
      && cur.over_sync[2] |=> cur.code == CODE_FULL)
    else $error("over range not clipped");
  chk_under_clip: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.st == ST_SEARCH && cur.step == STEP_LAST
      && !cur.over_sync[2] && cur.under_sync[2] |=> cur.code == CODE_ZERO)
    else $error("under range not clipped");
  chk_flag_set: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.clamp_sync[1] |=> !overvoltage_flag_n_o)
    else $error("clamp did not set flag");
  chk_flag_sticky: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) !overvoltage_flag_n_o && !config_read_i
      |=> !overvoltage_flag_n_o)
    else $error("flag cleared without read");
  chk_span_write: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) !span_write_i |=> $stable(span_enable_o))
    else $error("span changed without write");

  chk_span_load: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) span_write_i |=> span_enable_o == $past(span_value_i))
    else $error("span write not loaded");
  chk_switch_open: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) busy_o |-> !positive_array_ground_switch_o
      && !negative_array_ground_switch_o)
    else $error("array switches closed while busy");
  chk_switch_closed: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) !busy_o |-> positive_array_ground_switch_o
      && negative_array_ground_switch_o)
    else $error("array switches open while acquiring");
  chk_msb_trial: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cnv_rise && cur.st == ST_ACQ
      |=> dac_trial_o == CODE_MID)
    else $error("search did not start at msb");
  chk_step_advance: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.st == ST_SEARCH && cur.step < STEP_LAST
      |=> cur.st == ST_SEARCH && cur.step == $past(cur.step) + 5'h01)
    else $error("search step did not advance by one");
  chk_bit_drop: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.st == ST_SEARCH && cmp_q
      |=> (dac_trial_o & $past(bit_mask)) == CODE_ZERO)
    else $error("trial bit kept above input");
  chk_bit_keep: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.st == ST_SEARCH && !cmp_q
      |=> (dac_trial_o & $past(bit_mask)) == $past(bit_mask))
    else $error("trial bit dropped below input");
  chk_busy_hold: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) busy_o && cur.st != ST_DONE |=> busy_o)
    else $error("busy fell before done");
  chk_code_hold: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.st != ST_SEARCH |=> $stable(cur.code))
    else $error("code changed outside search");
  chk_result_hold: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) result_valid_o && !result_ready_i
      |=> result_valid_o && $stable(result_code_o))
    else $error("offered result not held");
  chk_flag_clear: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) config_read_i && !cur.clamp_sync[1]
      |=> overvoltage_flag_n_o)
    else $error("read with clamp off did not clear flag");
  chk_status_flag: assert property (@(posedge clock_i)
    disable iff (!arst_n_i) cur.st == ST_DONE && !result_valid_o
      |=> result_ov_n_o == $past(overvoltage_flag_n_o))
    else $error("status flag not paired with code");
endmodule : scs_sequencer

// >>> include/scs_pkg.sv
package scs_pkg;
  localparam int RES_W = 16;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_FULL = 16'hFFFF;
  localparam logic [4:0] STEP_LAST = 5'h0F;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 17;
  localparam logic SPAN_RESET = 1'b0;
  localparam logic OVF_N_RESET = 1'b1;
  localparam logic [4:0] STEP_RESET = 5'h00;
endpackage : scs_pkg

// >>> tb/scs_afe_model.sv
`timescale 1ns/1ns
module scs_afe_model (
  // array control from the sequencer
  input wire logic sw_closed_i,
  input wire logic [15:0] dac_trial_i,
  // level the bench puts on the inputs
  input wire logic [15:0] level_i,
  // comparator answer
  output logic comparator_high_o
);
  logic [15:0] held = 16'h0000;
  // level changes after the switch opens must not reach the search
  always @(negedge sw_closed_i) held = level_i;
  assign comparator_high_o = dac_trial_i > held;
endmodule : scs_afe_model

// >>> tb/scs_sequencer_test.sv
`timescale 1ns/1ns
module scs_sequencer_test;
  import scs_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic start = 1'b0, ovr = 1'b0, unr = 1'b0, clamp = 1'b0;
  logic span_wr = 1'b0, span_val = 1'b0, cfg_rd = 1'b0, ready = 1'b0;
  logic [15:0] level = 16'h0000;
  logic cmp, sw_p, sw_n, span_en, ov_n, busy, valid, res_ov, ovf;
  logic [15:0] trial, code;
  int fail_count = 0;
  int checks = 0;
  always #20 clock_i = ~clock_i;
  scs_afe_model afe (.sw_closed_i(sw_p), .dac_trial_i(trial),
    .level_i(level), .comparator_high_o(cmp));
  scs_sequencer uut (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .conversion_start_i(start), .comparator_high_i(cmp),
    .over_range_i(ovr), .under_range_i(unr), .clamp_active_i(clamp),
    .positive_array_ground_switch_o(sw_p),
    .negative_array_ground_switch_o(sw_n), .dac_trial_o(trial),
    .span_write_i(span_wr), .span_value_i(span_val),
    .config_read_i(cfg_rd), .span_enable_o(span_en),
    .overvoltage_flag_n_o(ov_n), .busy_o(busy), .result_valid_o(valid),
    .result_ready_i(ready), .result_code_o(code), .result_ov_n_o(res_ov),
    .overflow_o(ovf));
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : cmp1
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask : cmp16
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wait_cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    wait_cyc(1);
    s = 1'b0;
    wait_cyc(2);
  endtask : pulse
  // start is async, so it is held until busy proves it was seen
  task automatic convert(input logic [15:0] lv, input logic o, u);
    int n;
    @(negedge clock_i);
    level = lv;
    ovr = o;
    unr = u;
    start = 1'b1;
    for (n = 0; n < 10 && busy !== 1'b1; n++) @(negedge clock_i);
    if (busy !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: busy never rose", $time);
      test_done();
    end
    cmp1(sw_p, 1'b0);
    cmp1(sw_n, 1'b0);
    start = 1'b0;
    for (n = 0; n < 40 && busy === 1'b1; n++) @(negedge clock_i);
    cmp16(16'(n), 16'h0012);
    if (busy === 1'b1) test_done();
    cmp1(valid, 1'b1);
  endtask : convert
  task automatic pop(input logic [15:0] exp, input logic ov);
    cmp1(valid, 1'b1);
    cmp16(code, exp);
    cmp1(res_ov, ov);
    ready = 1'b1;
    wait_cyc(1);
    ready = 1'b0;
    wait_cyc(1);
  endtask : pop
  task automatic t_reset;
    cmp1(busy, 1'b0);
    cmp1(sw_p, 1'b1);
    cmp1(ov_n, OVF_N_RESET);
    cmp1(span_en, SPAN_RESET);
    cmp1(valid | ovf, 1'b0);
    cmp16(trial, CODE_MID);
    $display("reset test done");
  endtask : t_reset
  task automatic t_codes;
    logic [15:0] tab[6] = '{CODE_ZERO, 16'h0001, 16'h7FFF, CODE_MID,
      16'hA5C3, CODE_FULL};
    foreach (tab[i]) begin
      convert(tab[i], 1'b0, 1'b0);
      pop(tab[i], 1'b1);
      cmp1(sw_p, 1'b1);
    end
    convert(16'h1234, 1'b1, 1'b0);
    pop(CODE_FULL, 1'b1);
    convert(16'h1234, 1'b0, 1'b1);
    pop(CODE_ZERO, 1'b1);
    $display("code test done");
  endtask : t_codes
  task automatic t_flag;
    clamp = 1'b1;
    wait_cyc(4);
    cmp1(ov_n, 1'b0);
    pulse(cfg_rd);
    cmp1(ov_n, 1'b0);
    convert(16'h4000, 1'b0, 1'b0);
    pop(16'h4000, 1'b0);
    clamp = 1'b0;
    wait_cyc(4);
    cmp1(ov_n, 1'b0);
    pulse(cfg_rd);
    cmp1(ov_n, 1'b1);
    $display("flag test done");
  endtask : t_flag
  task automatic t_span;
    span_val = 1'b1;
    pulse(span_wr);
    cmp1(span_en, 1'b1);
    convert(16'h0100, 1'b0, 1'b1);
    pop(CODE_ZERO, 1'b1);
    span_val = 1'b0;
    pulse(span_wr);
    cmp1(span_en, 1'b0);
    $display("span test done");
  endtask : t_span
  // one more result than the buffer holds, with the reader stalled
  task automatic t_fifo;
    for (int i = 0; i <= FIFO_DEPTH; i++) convert(16'(i), 1'b0, 1'b0);
    wait_cyc(2);
    cmp1(ovf, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) pop(16'(i), 1'b1);
    cmp1(valid, 1'b0);
    $display("buffer test done");
  endtask : t_fifo
  initial begin
    wait_cyc(6);
    t_reset();
    arst_n_i = 1'b1;
    wait_cyc(2);
    t_codes();
    t_flag();
    t_span();
    t_fifo();
    test_done();
  end
endmodule : scs_sequencer_test
